// >>> design/vsrs_settings.sv
// Source, digital output and resistivity settings with a plain register port.
// Assumes a single-cycle strobe master and a fixture switch pin asynchronous to the clock.
//
// Behaviour
// RQ1 - Output line level follows set value and polarity.
// RQ2 - Amplitude span per range, default zero.
// RQ3 - Over-span amplitude on low range conflicts.
// RQ4 - Amplitude above enabled limit clamps to limit.
// RQ5 - Min and max resolve to active bound.
// RQ6 - Range value 100 or less selects low.
// RQ7 - Low range refused while amplitude exceeds 100.
// RQ8 - Limit 0 to 1000, default 1000, symmetric.
// RQ9 - Limit applies only while enabled.
// RQ10 - Enabling limit below present amplitude conflicts.
// RQ11 - Tie control closes low-terminal connection.
// RQ12 - Series resistor inserted when enabled.
// RQ13 - Thickness stored within 0.0001 to 99.9999.
// RQ14 - Dedicated fixture switch sets resistivity type.
// RQ15 - User fixture takes type from selection.
// RQ16 - Host supplies surface factor in range.
// RQ17 - Host supplies volume factor in range.
// RQ18 - Conflicts leave previous settings unchanged; a conflicting control write still updates its other bits.
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "vsrs_defines.svh"
module vsrs_settings
	import vsrs_pkg::*;
#(
	parameter int DOUT_W = 4
) (
	// Clock and reset
	input  wire logic              clk_sys_in,
	input  wire logic              rst_n_in,
	// Register port
	input  wire logic [3:0]        reg_addr_in,
	input  wire logic [31:0]       reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output logic [31:0]            reg_rdata_out,
	// Fixture sense
	input  wire logic              fixture_switch_in,
	// Source controls
	output logic                   range_high_out,
	output logic signed [31:0]     ampl_mv_out,
	output logic [31:0]            limit_mv_out,
	output logic                   limit_en_out,
	output logic                   low_terminal_tie_control_out,
	output logic                   series_resistor_current_limit_out,
	output logic                   resistivity_volume_out,
	// Digital outputs and interrupt
	output logic [DOUT_W-1:0]      dout_lines_out,
	output logic                   irq_out
);

	// The line field is cut from one 32-bit data word, so wider ports cannot be served.
	if (DOUT_W < 1 || DOUT_W > 32) begin : g_dout_w_check
		$error("vsrs_settings: DOUT_W must be 1 to 32");
	end

	vsrs_range_t         range_r;
	logic signed [31:0]  ampl_r;
	logic [31:0]         limit_r;
	logic                lim_en_r;
	logic                lo_tie_r;
	logic                res_lim_r;
	logic                fix_user_r;
	vsrs_rtype_t         rsel_r;
	logic [DOUT_W-1:0]   dout_set_r;
	logic [DOUT_W-1:0]   dout_pol_r;
	logic [31:0]         thick_r;
	logic [31:0]         ksurf_r;
	logic [31:0]         kvol_r;
	logic [2:0]          status_r;
	logic [2:0]          mask_r;
	logic                fix_sw;
	vsrs_rtype_t         rtype;

	logic                wr_ampl;
	logic                wr_range;
	logic                wr_ctrl;
	logic signed [31:0]  chk_ampl;
	logic                chk_conflict;
	logic                chk_clamped;
	logic [1:0]          chk_cmd;
	logic [31:0]         wmag;
	logic [31:0]         amag;
	logic                ev_conflict;
	logic                ev_clamped;
	logic                ev_bad;

	function automatic logic [31:0] vsrs_abs(input logic signed [31:0] v);
		vsrs_abs = v[31] ? 32'(-v) : 32'(v);
	endfunction : vsrs_abs

	function automatic logic vsrs_in_span(input logic [31:0] v, input logic [31:0] lo,
	                                      input logic [31:0] hi);
		vsrs_in_span = (v >= lo) && (v <= hi);
	endfunction : vsrs_in_span

	vsrs_in_sync u_fix_sync (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.pin_in     (fixture_switch_in),
		.level_out  (fix_sw)
	);

	assign wr_ampl  = reg_wr_in && (reg_addr_in == `VSRS_OFF_AMPL
	                               || reg_addr_in == `VSRS_OFF_AMPL_CMD);
	assign chk_cmd  = (reg_addr_in == `VSRS_OFF_AMPL_CMD) ? reg_wdata_in[1:0] : `VSRS_CMD_VALUE;

	vsrs_amp_check u_amp_check (
		.cmd_in       (chk_cmd),
		.req_in       (reg_wdata_in),
		.range_in     (range_r),
		.lim_en_in    (lim_en_r),
		.limit_in     (limit_r),
		.ampl_out     (chk_ampl),
		.conflict_out (chk_conflict),
		.clamped_out  (chk_clamped)
	);

	assign wr_range = reg_wr_in && reg_addr_in == `VSRS_OFF_RANGE;
	assign wr_ctrl  = reg_wr_in && reg_addr_in == `VSRS_OFF_CTRL;
	assign wmag     = reg_wdata_in;
	assign amag     = vsrs_abs(ampl_r);

	// Dedicated fixture reports its switch; a user fixture uses the programmed choice.
	assign rtype = fix_user_r ? rsel_r : vsrs_rtype_t'(fix_sw); // RQ14 RQ15

	// Source range and amplitude.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			range_r <= VSRS_RANGE_LOW; // RQ6
			ampl_r  <= 32'sh0; // RQ2
		end else begin
			if (wr_ampl && !chk_conflict) begin
				ampl_r <= chk_ampl; // RQ18
			end
			if (wr_range && wmag <= `VSRS_HIGH_SPAN_MV) begin
				if (wmag > `VSRS_LOW_SPAN_MV) begin
					range_r <= VSRS_RANGE_HIGH; // RQ6
				end else if (amag <= `VSRS_LOW_SPAN_MV) begin
					range_r <= VSRS_RANGE_LOW; // RQ7 RQ18
				end
			end
		end
	end

	// Limit value and control bits.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			limit_r    <= `VSRS_LIMIT_RST_MV; // RQ8
			lim_en_r   <= 1'b0;
			lo_tie_r   <= 1'b0;
			res_lim_r  <= 1'b0;
			fix_user_r <= 1'b0;
			rsel_r     <= VSRS_SURFACE;
		end else begin
			if (reg_wr_in && reg_addr_in == `VSRS_OFF_LIMIT && wmag <= `VSRS_HIGH_SPAN_MV) begin
				limit_r <= wmag; // RQ8
			end
			if (wr_ctrl) begin
				if (!reg_wdata_in[`VSRS_CTRL_LIM_EN] || amag <= limit_r) begin
					lim_en_r <= reg_wdata_in[`VSRS_CTRL_LIM_EN]; // RQ10 RQ18
				end
				lo_tie_r   <= reg_wdata_in[`VSRS_CTRL_LO_TIE]; // RQ11
				res_lim_r  <= reg_wdata_in[`VSRS_CTRL_RES_LIM]; // RQ12
				fix_user_r <= reg_wdata_in[`VSRS_CTRL_FIX_USER];
				rsel_r     <= vsrs_rtype_t'(reg_wdata_in[`VSRS_CTRL_RSEL_VOL]); // RQ15
			end
		end
	end

	// Resistivity parameters; out-of-range values are dropped and reported.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			thick_r <= `VSRS_THICK_RST;
			ksurf_r <= `VSRS_K_RST;
			kvol_r  <= `VSRS_K_RST;
		end else if (reg_wr_in) begin
			if (reg_addr_in == `VSRS_OFF_THICK
			    && vsrs_in_span(wmag, `VSRS_THICK_MIN, `VSRS_THICK_MAX)) begin
				thick_r <= wmag; // RQ13
			end
			if (reg_addr_in == `VSRS_OFF_KSURF
			    && vsrs_in_span(wmag, `VSRS_K_MIN, `VSRS_K_MAX)) begin
				ksurf_r <= wmag; // RQ16
			end
			if (reg_addr_in == `VSRS_OFF_KVOL
			    && vsrs_in_span(wmag, `VSRS_K_MIN, `VSRS_K_MAX)) begin
				kvol_r <= wmag; // RQ17
			end
		end
	end

	// Digital output set values and polarity.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dout_set_r <= '0;
			dout_pol_r <= '0;
		end else begin
			if (reg_wr_in && reg_addr_in == `VSRS_OFF_DOUT) begin
				dout_set_r <= reg_wdata_in[DOUT_W-1:0];
			end
			if (reg_wr_in && reg_addr_in == `VSRS_OFF_POL) begin
				dout_pol_r <= reg_wdata_in[DOUT_W-1:0];
			end
		end
	end

	// Events feeding the sticky status.
	assign ev_conflict = (wr_ampl && chk_conflict)
	                   || (wr_range && wmag <= `VSRS_HIGH_SPAN_MV
	                       && wmag <= `VSRS_LOW_SPAN_MV && amag > `VSRS_LOW_SPAN_MV) // RQ7
	                   || (wr_ctrl && reg_wdata_in[`VSRS_CTRL_LIM_EN] && amag > limit_r); // RQ10
	assign ev_clamped  = wr_ampl && chk_clamped;
	assign ev_bad = reg_wr_in && (
	          ((reg_addr_in == `VSRS_OFF_RANGE || reg_addr_in == `VSRS_OFF_LIMIT)
	           && wmag > `VSRS_HIGH_SPAN_MV)
	        || (reg_addr_in == `VSRS_OFF_THICK
	            && !vsrs_in_span(wmag, `VSRS_THICK_MIN, `VSRS_THICK_MAX))
	        || ((reg_addr_in == `VSRS_OFF_KSURF || reg_addr_in == `VSRS_OFF_KVOL)
	            && !vsrs_in_span(wmag, `VSRS_K_MIN, `VSRS_K_MAX)));

	// Sticky status: a new event in the clearing cycle wins over the clear.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_r <= 3'h0;
			mask_r   <= 3'h0;
		end else begin
			status_r <= (status_r & ~((reg_wr_in && reg_addr_in == `VSRS_OFF_STATUS)
			                          ? reg_wdata_in[2:0] : 3'h0))
			          | {ev_bad, ev_clamped, ev_conflict}; // RQ3
			if (reg_wr_in && reg_addr_in == `VSRS_OFF_MASK) begin
				mask_r <= reg_wdata_in[2:0];
			end
		end
	end

	// Registered outputs.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			range_high_out                    <= 1'b0;
			ampl_mv_out                       <= 32'sh0;
			limit_mv_out                      <= `VSRS_LIMIT_RST_MV;
			limit_en_out                      <= 1'b0;
			low_terminal_tie_control_out      <= 1'b0;
			series_resistor_current_limit_out <= 1'b0;
			resistivity_volume_out            <= 1'b0;
			dout_lines_out                    <= '0;
			irq_out                           <= 1'b0;
		end else begin
			range_high_out                    <= (range_r == VSRS_RANGE_HIGH);
			ampl_mv_out                       <= ampl_r;
			limit_mv_out                      <= limit_r;
			limit_en_out                      <= lim_en_r; // RQ9
			low_terminal_tie_control_out      <= lo_tie_r; // RQ11
			series_resistor_current_limit_out <= res_lim_r; // RQ12
			resistivity_volume_out            <= (rtype == VSRS_VOLUME); // RQ14
			// A set polarity bit marks an active-low line.
			dout_lines_out                    <= dout_set_r ^ dout_pol_r; // RQ1
			irq_out                           <= |(status_r & mask_r);
		end
	end

	// Read data stands in the cycle after the strobe only.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 32'h0;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				`VSRS_OFF_AMPL:   reg_rdata_out <= ampl_r;
				`VSRS_OFF_RANGE:  reg_rdata_out <= (range_r == VSRS_RANGE_HIGH)
				                                   ? `VSRS_HIGH_SPAN_MV : `VSRS_LOW_SPAN_MV;
				`VSRS_OFF_LIMIT:  reg_rdata_out <= limit_r;
				`VSRS_OFF_CTRL:   reg_rdata_out <= {27'h0, rsel_r, fix_user_r, res_lim_r,
				                                    lo_tie_r, lim_en_r};
				`VSRS_OFF_DOUT:   reg_rdata_out <= 32'(dout_set_r);
				`VSRS_OFF_POL:    reg_rdata_out <= 32'(dout_pol_r);
				`VSRS_OFF_THICK:  reg_rdata_out <= thick_r;
				`VSRS_OFF_KSURF:  reg_rdata_out <= ksurf_r;
				`VSRS_OFF_KVOL:   reg_rdata_out <= kvol_r;
				// At the command offset, bit 1 reports the sensed fixture switch, bit 0 the effective type.
				`VSRS_OFF_STATUS: reg_rdata_out <= {29'h0, status_r};
				`VSRS_OFF_MASK:   reg_rdata_out <= {29'h0, mask_r};
				`VSRS_OFF_AMPL_CMD: reg_rdata_out <= {30'h0, fix_sw, rtype == VSRS_VOLUME}; // RQ14
				default:          reg_rdata_out <= 32'h0;
			endcase
		end else begin
			reg_rdata_out <= 32'h0;
		end
	end

endmodule : vsrs_settings

// >>> shared/vsrs_defines.svh
// Constants for the source and resistivity settings block.
// Assumes values are fixed-point integers: volts in millivolts, factors in thousandths.
`ifndef VSRS_DEFINES_SVH
`define VSRS_DEFINES_SVH

// Register offsets (word index on the plain register port).
`define VSRS_OFF_AMPL     4'h0
`define VSRS_OFF_RANGE    4'h1
`define VSRS_OFF_LIMIT    4'h2
`define VSRS_OFF_CTRL     4'h3
`define VSRS_OFF_DOUT     4'h4
`define VSRS_OFF_POL      4'h5
`define VSRS_OFF_THICK    4'h6
`define VSRS_OFF_KSURF    4'h7
`define VSRS_OFF_KVOL     4'h8
`define VSRS_OFF_STATUS   4'h9
`define VSRS_OFF_MASK     4'ha
`define VSRS_OFF_AMPL_CMD 4'hb

// Control register fields.
`define VSRS_CTRL_LIM_EN   0
`define VSRS_CTRL_LO_TIE   1
`define VSRS_CTRL_RES_LIM  2
`define VSRS_CTRL_FIX_USER 3
`define VSRS_CTRL_RSEL_VOL 4

// Status register fields.
`define VSRS_ST_CONFLICT   0
`define VSRS_ST_CLAMPED    1
`define VSRS_ST_BAD_PARAM  2

// Amplitude command codes for the special requests.
`define VSRS_CMD_VALUE     2'h0
`define VSRS_CMD_MIN       2'h1
`define VSRS_CMD_MAX       2'h2
`define VSRS_CMD_DEFAULT   2'h3

// Numeric spans, in millivolts, micrometres tenths and thousandths.
`define VSRS_LOW_SPAN_MV   32'd100000
`define VSRS_HIGH_SPAN_MV  32'd1000000
`define VSRS_LIMIT_RST_MV  32'd1000000
`define VSRS_THICK_MIN     32'd1
`define VSRS_THICK_MAX     32'd999999
`define VSRS_K_MIN         32'd1
`define VSRS_K_MAX         32'd999999
`define VSRS_THICK_RST     32'd10000
`define VSRS_K_RST         32'd1000
`define VSRS_NORM_LIM_UA   32'd1000

`endif

// >>> shared/vsrs_pkg.sv
// Types for the source and resistivity settings block.
// Assumes the defines header is included by each user.
package vsrs_pkg;

	typedef enum logic [0:0] {
		VSRS_RANGE_LOW  = 1'b0,
		VSRS_RANGE_HIGH = 1'b1
	} vsrs_range_t;

	typedef enum logic [0:0] {
		VSRS_SURFACE = 1'b0,
		VSRS_VOLUME  = 1'b1
	} vsrs_rtype_t;

endpackage : vsrs_pkg

// >>> design/vsrs_in_sync.sv
// Three-stage synchroniser for a pin level with agreement filtering.
// Assumes the input is asynchronous to clk_sys_in.
`timescale 1ns/1ps
module vsrs_in_sync (
	// Clock and reset
	input  wire logic clk_sys_in,
	input  wire logic rst_n_in,
	// Pin and clean level
	input  wire logic pin_in,
	output logic      level_out
);

	logic s1_r;
	logic s2_r;
	logic s3_r;

	// The first stage feeds only the second; the level moves once stages two and three agree.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1_r      <= 1'b0;
			s2_r      <= 1'b0;
			s3_r      <= 1'b0;
			level_out <= 1'b0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level_out <= s3_r;
			end
		end
	end

endmodule : vsrs_in_sync

// >>> design/vsrs_amp_check.sv
// Combinational amplitude evaluator: bound, clamp and conflict decision.
// Assumes signed millivolt values; registered by the caller.
`timescale 1ns/1ps
`include "vsrs_defines.svh"
module vsrs_amp_check
	import vsrs_pkg::*;
(
	// Request
	input  wire logic [1:0]         cmd_in,
	input  wire logic signed [31:0] req_in,
	// Present settings
	input  vsrs_range_t             range_in,
	input  wire logic               lim_en_in,
	input  wire logic [31:0]        limit_in,
	// Result
	output logic signed [31:0]      ampl_out,
	output logic                    conflict_out,
	output logic                    clamped_out
);

	logic [31:0] span;
	logic [31:0] bound;
	logic [31:0] mag;

	always_comb begin
		span  = (range_in == VSRS_RANGE_LOW) ? `VSRS_LOW_SPAN_MV : `VSRS_HIGH_SPAN_MV;
		// An enabled limit narrows the bound; otherwise the range alone rules.
		bound = (lim_en_in && limit_in < span) ? limit_in : span; // RQ9 RQ8
		mag   = req_in[31] ? 32'(-req_in) : 32'(req_in);
		ampl_out     = req_in;
		conflict_out = 1'b0;
		clamped_out  = 1'b0;
		unique case (cmd_in)
			`VSRS_CMD_MIN: ampl_out = -$signed(bound); // RQ5
			`VSRS_CMD_MAX: ampl_out = $signed(bound); // RQ5
			`VSRS_CMD_DEFAULT: ampl_out = 32'sd0; // RQ2
			default: begin
				if (mag > span && !(lim_en_in && limit_in < span)) begin
					conflict_out = 1'b1; // RQ3 RQ2
				end else if (mag > bound) begin
					// Clamp keeps the sign of the request.
					ampl_out    = req_in[31] ? -$signed(bound) : $signed(bound); // RQ4
					clamped_out = 1'b1;
				end
			end
		endcase
	end

endmodule : vsrs_amp_check

// >>> testbench/vsrs_monitor.sv
// Checker for the settings block outputs.
// Assumes it is bound to every settings instance.
`timescale 1ns/1ps
module vsrs_monitor #(
	parameter int DOUT_W = 4
) (
	// Clock, reset and register port
	input wire logic               clk_sys_in,
	input wire logic               rst_n_in,
	input wire logic [3:0]         reg_addr_in,
	input wire logic [31:0]        reg_wdata_in,
	input wire logic               reg_wr_in,
	input wire logic               reg_rd_in,
	input wire logic [31:0]        reg_rdata_out,
	// Source and line outputs
	input wire logic               range_high_out,
	input wire logic signed [31:0] ampl_mv_out,
	input wire logic [31:0]        limit_mv_out,
	input wire logic               limit_en_out,
	input wire logic               low_terminal_tie_control_out,
	input wire logic               series_resistor_current_limit_out,
	input wire logic [DOUT_W-1:0]  dout_lines_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	logic [31:0] mag;
	assign mag = ampl_mv_out[31] ? -ampl_mv_out : ampl_mv_out;

	a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data not zero outside answer");
	a_low_span: assert property (!range_high_out |-> mag <= 32'h186a0)
		else $error("low range amplitude over span");
	a_full_span: assert property (mag <= 32'hf4240)
		else $error("amplitude over full span");
	a_limit_span: assert property (limit_mv_out <= 32'hf4240)
		else $error("limit over span");
	a_enable_fit: assert property ($rose(limit_en_out) |-> mag <= limit_mv_out)
		else $error("limit enabled below amplitude");
	a_dout_cause: assert property ($changed(dout_lines_out) |->
		$past(reg_wr_in, 2) && $past(reg_addr_in, 2) inside {4'h4, 4'h5})
		else $error("output lines changed without write");
	a_range_cause: assert property ($changed(range_high_out) |->
		$past(reg_wr_in, 2) && $past(reg_addr_in, 2) == 4'h1)
		else $error("range changed without write");
	a_tie_value: assert property ($past(reg_wr_in, 2) && $past(reg_addr_in, 2) == 4'h3 |->
		low_terminal_tie_control_out == $past(reg_wdata_in[1], 2))
		else $error("tie control does not follow write");
	a_series_value: assert property ($past(reg_wr_in, 2) && $past(reg_addr_in, 2) == 4'h3 |->
		series_resistor_current_limit_out == $past(reg_wdata_in[2], 2))
		else $error("series resistor does not follow write");
endmodule : vsrs_monitor

bind vsrs_settings vsrs_monitor #(.DOUT_W(DOUT_W)) vsrs_monitor_inst (
	.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
	.reg_rdata_out, .range_high_out, .ampl_mv_out, .limit_mv_out, .limit_en_out,
	.low_terminal_tie_control_out, .series_resistor_current_limit_out, .dout_lines_out
);

// >>> testbench/vsrs_host_model.sv
// Host controller model for the settings register port.
// Assumes a slave that never stalls and answers reads one cycle later.
`timescale 1ns/1ps
module vsrs_host_model (
	// Clock
	input  wire logic        clk_sys_in,
	// Register port
	output logic [3:0]       reg_addr_out,
	output logic [31:0]      reg_wdata_out,
	output logic             reg_wr_out,
	output logic             reg_rd_out,
	input  wire logic [31:0] reg_rdata_in
);
	initial begin
		reg_addr_out = 4'h0;
		reg_wdata_out = 32'h0;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
	end
	// Released data lines show the inverse so a stale value is never mistaken for a live one.
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys_in);
		reg_addr_out <= a;
		reg_wdata_out <= v;
		reg_wr_out <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr_out <= 1'b0;
		reg_wdata_out <= ~v;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk_sys_in);
		reg_addr_out <= a;
		reg_rd_out <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd_out <= 1'b0;
		#1;
		v = reg_rdata_in;
	endtask : rd
	task automatic put_k(input logic [3:0] a, input logic [31:0] v);
		wr(a, (v >= 32'h1 && v <= 32'hf423f) ? v : 32'h1);
	endtask : put_k
endmodule : vsrs_host_model

// >>> testbench/tb_top.sv
// Self-checking bench for the settings block.
// Assumes the host model drives the register port and the bench drives the fixture pin.
`timescale 1ns/1ps
module tb_top;
	logic               clk_sys_in, rst_n_in, fixture_switch_in;
	logic [3:0]         reg_addr_in;
	logic [31:0]        reg_wdata_in, reg_rdata_out, limit_mv_out, s, p, v, d;
	logic               reg_wr_in, reg_rd_in, range_high_out, limit_en_out, irq_out;
	logic signed [31:0] ampl_mv_out;
	logic               low_terminal_tie_control_out, series_resistor_current_limit_out;
	logic               resistivity_volume_out;
	logic [3:0]         dout_lines_out;
	logic [31:0]        seed = 32'hca871900;
	int                 failures = 0, checks = 0;

	vsrs_settings vsrs_settings_inst (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .fixture_switch_in, .range_high_out,
		.ampl_mv_out, .limit_mv_out, .limit_en_out, .low_terminal_tie_control_out,
		.series_resistor_current_limit_out, .resistivity_volume_out, .dout_lines_out, .irq_out);
	vsrs_host_model vsrs_host_model_inst (.clk_sys_in, .reg_addr_out(reg_addr_in),
		.reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
		.reg_rdata_in(reg_rdata_out));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [31:0] clampv(logic signed [31:0] x, logic signed [31:0] b);
		return x > b ? b : (x < -b ? -b : x);
	endfunction : clampv
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic test_done();
		if (failures == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic w(input logic [3:0] a, input logic [31:0] x);
		vsrs_host_model_inst.wr(a, x);
	endtask : w
	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		vsrs_host_model_inst.rd(a, d);
		chk(d, e);
	endtask : rc
	// Outputs pass one flop after the internal state, so two edges are waited.
	task automatic st();
		repeat (2) @(posedge clk_sys_in);
		#1;
	endtask : st
	task automatic rst();
		rst_n_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		#1;
		chk(limit_mv_out, 32'hf4240);
		chk(ampl_mv_out, 32'h0);
		chk({range_high_out, limit_en_out, irq_out, dout_lines_out}, 32'h0);
	endtask : rst

	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		failures++;
		test_done();
	end
	initial begin
		rst_n_in = 1'b0;
		fixture_switch_in = 1'b0;
		rst();
		repeat (6) begin
			s = rnd();
			p = rnd();
			w(4'h4, s);
			w(4'h5, p);
			st();
			chk({28'h0, dout_lines_out}, {28'h0, s[3:0] ^ p[3:0]});
		end
		w(4'h9, 32'h7);
		w(4'h0, 32'h186a0); st(); chk(ampl_mv_out, 32'h186a0);
		w(4'h0, 32'h186a1); st(); chk(ampl_mv_out, 32'h186a0);
		rc(4'h9, 32'h1);
		w(4'h1, 32'h186a1); st(); chk(range_high_out, 32'h1);
		rc(4'h1, 32'hf4240);
		w(4'h0, 32'hfff0bdc0); st(); chk(ampl_mv_out, 32'hfff0bdc0);
		w(4'h9, 32'h7);
		w(4'h1, 32'h186a0); st(); chk(range_high_out, 32'h1);
		rc(4'h9, 32'h1);
		w(4'h0, 32'h61a80);
		w(4'h2, 32'h493e0);
		w(4'h9, 32'h7);
		w(4'h3, 32'h1); st(); chk(limit_en_out, 32'h0);
		rc(4'h9, 32'h1);
		w(4'h2, 32'hf4241); st(); chk(limit_mv_out, 32'h493e0);
		w(4'h2, 32'h7a120);
		w(4'h3, 32'h1); st(); chk(limit_en_out, 32'h1);
		repeat (6) begin
			v = rnd() % 32'd2000001 - 32'd1000000;
			w(4'h0, v); st(); chk(ampl_mv_out, clampv(v, 32'sd500000));
		end
		w(4'h9, 32'h7);
		w(4'h0, 32'h927c0); st(); chk(ampl_mv_out, 32'h7a120);
		rc(4'h9, 32'h2);
		w(4'hb, 32'h1); st(); chk(ampl_mv_out, 32'hfff85ee0);
		w(4'hb, 32'h2); st(); chk(ampl_mv_out, 32'h7a120);
		w(4'h3, 32'h0);
		w(4'hb, 32'h2); st(); chk(ampl_mv_out, 32'hf4240);
		w(4'hb, 32'h3); st(); chk(ampl_mv_out, 32'h0);
		w(4'hb, 32'h4); st(); chk(ampl_mv_out, 32'h4);
		w(4'ha, 32'h2); st(); chk(irq_out, 32'h1);
		w(4'ha, 32'h0); st(); chk(irq_out, 32'h0);
		w(4'ha, 32'h2);
		w(4'h9, 32'h2); st(); chk(irq_out, 32'h0);
		w(4'h3, 32'h6); st(); chk({low_terminal_tie_control_out, series_resistor_current_limit_out}, 32'h3);
		@(posedge clk_sys_in);
		fixture_switch_in <= 1'b1;
		repeat (8) @(posedge clk_sys_in);
		#1;
		chk(resistivity_volume_out, 32'h1);
		rc(4'hb, 32'h3);
		w(4'h3, 32'h8); st(); chk(resistivity_volume_out, 32'h0);
		chk({low_terminal_tie_control_out, series_resistor_current_limit_out}, 32'h0);
		w(4'h3, 32'h18); st(); chk(resistivity_volume_out, 32'h1);
		w(4'h9, 32'h7);
		w(4'h6, 32'hf423f); rc(4'h6, 32'hf423f);
		w(4'h6, 32'h0); rc(4'h6, 32'hf423f);
		rc(4'h9, 32'h4);
		w(4'hf, 32'hffffffff); rc(4'h6, 32'hf423f);
		for (int i = 7; i <= 8; i++) begin
			v = rnd() % 32'd999999 + 32'd1;
			vsrs_host_model_inst.put_k(i[3:0], v);
			rc(i[3:0], v);
		end
		@(posedge clk_sys_in);
		rst();
		rc(4'h6, 32'h2710);
		rc(4'h7, 32'h3e8);
		test_done();
	end
endmodule : tb_top
